// file: logic/serial_config_pkg.sv
// constants, states and option bundle of the serial configuration sequencer
package serial_config_pkg;
  localparam int CLK_PERIOD_NS      = 100;
  localparam int CF2CD_MAX_NS       = 600;
  localparam int CF2CD_CYC          = CF2CD_MAX_NS / CLK_PERIOD_NS;
  localparam int STATUS_MIN_US      = 268;
  localparam int STATUS_MIN_CYC     = (STATUS_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STATUS_MAX_US      = 1506;
  localparam int STATUS_MAX_CYC     = STATUS_MAX_US * 1000 / CLK_PERIOD_NS;
  localparam int UM_MIN_US          = 175;
  localparam int UM_MIN_CYC         = (UM_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int UM_MAX_US          = 437;
  localparam int UM_MAX_CYC         = UM_MAX_US * 1000 / CLK_PERIOD_NS;
  localparam int CD2CU_PERIODS      = 4;
  localparam int CCLK_MAX_PERIOD_NS = 189;
  localparam int CD2CU_CYC          = (CD2CU_PERIODS * CCLK_MAX_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int USER_INIT_CYCLES   = 8576;
  localparam int TRAIL_FALLS        = 2;
  localparam int POR_CYC            = 64;
  localparam int LOAD_BITS          = 4096;
  localparam int AS_BASE_HALF       = 1;
  localparam logic [1:0] AS_RATE_TOP = 2'h3;
  localparam logic [7:0] FLASH_READ_CMD = 8'h03;
  localparam logic [3:0] CMD_BITS   = 4'h8;
  localparam logic [3:0] BYTE_BITS  = 4'h8;

  typedef enum logic [3:0] {
    ST_POR      = 4'b0000,
    ST_HOLD     = 4'b0001,
    ST_RELEASE  = 4'b0010,
    ST_LOAD     = 4'b0011,
    ST_TRAIL    = 4'b0100,
    ST_INIT_OSC = 4'b0101,
    ST_INIT_USR = 4'b0110,
    ST_USER     = 4'b0111,
    ST_ERROR    = 4'b1000
  } cfg_state_t;

  typedef struct packed {
    logic       scheme_as;
    logic       as_x4;
    logic [1:0] rate_sel;
    logic       chained;
    logic       init_user_clk;
    logic       init_done_en;
    logic       dual_user;
  } cfg_opts_t;
endpackage

// file: logic/serial_config_sequencer.sv
// serial configuration sequencer with its byte fifo
`timescale 1ns/10ps
`default_nettype none

module cfg_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // fill side
  input  wire logic [WIDTH-1:0] wr_data_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  // drain side
  output logic [WIDTH-1:0]      rd_data_out,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } fifo_st_t;
  fifo_st_t         q;
  fifo_st_t         d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             full;
  logic             empty;

  assign full         = (q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]);
  assign empty        = (q.wp == q.rp);
  assign wr_ready_out = !full;
  assign rd_valid_out = !empty;
  assign rd_data_out  = mem[q.rp[AW-1:0]];

  always_comb begin
    d = q;
    if (wr_valid_in && !full) begin
      d.wp = q.wp + 1'b1;
    end
    if (rd_ready_in && !empty) begin
      d.rp = q.rp + 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
    if (wr_valid_in && !full) begin
      mem[q.wp[AW-1:0]] <= wr_data_in;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////

module serial_config_sequencer #(
  parameter int STATUS_MAX_P = serial_config_pkg::STATUS_MAX_CYC,
  parameter int UM_MAX_P     = serial_config_pkg::UM_MAX_CYC,
  parameter int USER_INIT_P  = serial_config_pkg::USER_INIT_CYCLES,
  parameter int LOAD_BITS_P  = serial_config_pkg::LOAD_BITS,
  parameter int FIFO_DEPTH   = 32
) (
  // clock and reset
  input  wire logic                         clk_in,
  input  wire logic                         rst_in,
  // option straps
  input  wire serial_config_pkg::cfg_opts_t opts_in,
  // request and status handshake
  input  wire logic                         config_request_n_in,
  input  wire logic                         status_n_in,
  output logic                              status_n_out,
  output logic                              status_n_oe_out,
  output logic                              load_done_out,
  output logic                              init_done_n_out,
  output logic                              init_done_n_oe_out,
  output logic                              user_mode_out,
  // configuration clock pin
  input  wire logic                         config_clock_in,
  output logic                              config_clock_out,
  output logic                              config_clock_oe_out,
  // passive serial data pin
  input  wire logic                         serial_data_in,
  output logic                              user_pin_release_out,
  // serial flash pins
  input  wire logic [3:0]                   serial_flash_data_in,
  output logic                              flash_command_out,
  output logic                              flash_select_n_out,
  // start-up clock pin
  input  wire logic                         user_startup_clock_in,
  // received configuration bytes
  output logic [7:0]                        byte_out,
  output logic                              byte_valid_out,
  input  wire logic                         byte_ready_in
);
  localparam int NS      = 17;
  localparam int REQ_MAX = serial_config_pkg::CF2CD_CYC;

  typedef struct packed {
    serial_config_pkg::cfg_state_t st;
    logic [15:0] cnt;
    logic [23:0] bits;
    logic [13:0] edges;
    logic [3:0]  div;
    logic [3:0]  nb;
    logic [7:0]  shreg;
    logic [7:0]  cmd;
    logic [3:0]  cmdn;
    logic        cclk;
    logic        cclk_prev;
    logic        uclk_prev;
    logic        ncfg_prev;
    logic        status_drive;
    logic        done;
    logic        init_low;
    logic        sel_n;
    logic        user_pin;
    logic        user_mode;
    logic        push;
    logic [7:0]  push_data;
    logic        err;
  } seq_st_t;

  seq_st_t                      q;
  seq_st_t                      d;
  logic [NS-1:0]                raw;
  logic [NS-1:0]                s1_q;
  logic [NS-1:0]                s2_q;
  serial_config_pkg::cfg_opts_t opts;
  logic                         s_ncfg;
  logic                         s_stat;
  logic                         s_cclk;
  logic                         s_data;
  logic [3:0]                   s_flash;
  logic                         s_uclk;
  logic                         ps_rise;
  logic                         ps_fall;
  logic                         u_rise;
  logic                         req_fall;
  logic [1:0]                   rate;
  logic [3:0]                   half_m1;
  logic                         fifo_ready;
  logic                         take;
  logic                         w4;
  logic [3:0]                   tb;
  logic [7:0]                   sh;
  logic [3:0]                   nbn;

  //////////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers for every pin and strap
  assign raw = {opts_in, config_request_n_in, status_n_in, config_clock_in,
                serial_data_in, serial_flash_data_in, user_startup_clock_in};

  for (genvar i = 0; i < NS; i++) begin : g_sync
    always_ff @(posedge clk_in) begin
      if (rst_in) begin
        s1_q[i] <= 1'b0;
        s2_q[i] <= 1'b0;
      end else begin
        s1_q[i] <= raw[i];
        s2_q[i] <= s1_q[i];
      end
    end
  end

  assign opts     = serial_config_pkg::cfg_opts_t'(s2_q[16:9]);
  assign s_ncfg   = s2_q[8];
  assign s_stat   = s2_q[7];
  assign s_cclk   = s2_q[6];
  assign s_data   = s2_q[5];
  assign s_flash  = s2_q[4:1];
  assign s_uclk   = s2_q[0];
  assign ps_rise  = s_cclk && !q.cclk_prev;
  assign ps_fall  = !s_cclk && q.cclk_prev;
  assign u_rise   = s_uclk && !q.uclk_prev;
  assign req_fall = !s_ncfg && q.ncfg_prev;

  // chained loading never runs at the fastest rate
  assign rate    = (opts.chained && opts.rate_sel == serial_config_pkg::AS_RATE_TOP) ?
                   serial_config_pkg::AS_RATE_TOP - 2'h1 : opts.rate_sel;
  assign half_m1 = 4'((serial_config_pkg::AS_BASE_HALF << (2'h3 - rate)) - 1);

  //////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_comb begin
    d           = q;
    d.push      = 1'b0;
    d.cclk_prev = s_cclk;
    d.uclk_prev = s_uclk;
    d.ncfg_prev = s_ncfg;
    take        = 1'b0;
    w4          = 1'b0;
    tb          = 4'h0;
    sh          = q.shreg;
    nbn         = q.nb;
    if (q.push && !fifo_ready) begin
      d.err = 1'b1;
    end
    case (q.st)
      serial_config_pkg::ST_POR: begin
        d.status_drive = 1'b1;
        d.cnt          = q.cnt + 16'h1;
        if (q.cnt == 16'(serial_config_pkg::POR_CYC - 1)) begin
          d.st  = serial_config_pkg::ST_HOLD;
          d.cnt = 16'h0;
        end
      end
      serial_config_pkg::ST_HOLD: begin
        d.status_drive = 1'b1;
        d.done         = 1'b0;
        if (q.cnt < 16'(STATUS_MAX_P)) begin
          d.cnt = q.cnt + 16'h1;
        end
        if (s_ncfg && q.cnt >= 16'(serial_config_pkg::STATUS_MIN_CYC - 1)) begin
          d.st           = serial_config_pkg::ST_RELEASE;
          d.status_drive = 1'b0;
        end
      end
      serial_config_pkg::ST_RELEASE: begin
        // an outside party may keep status low to delay loading
        if (s_stat) begin
          d.st    = serial_config_pkg::ST_LOAD;
          d.bits  = 24'h0;
          d.nb    = 4'h0;
          d.cmd   = serial_config_pkg::FLASH_READ_CMD;
          d.cmdn  = 4'h0;
          d.div   = 4'h0;
          d.cclk  = 1'b0;
          d.err   = 1'b0;
          d.sel_n = !opts.scheme_as;
        end
      end
      serial_config_pkg::ST_LOAD: begin
        if (opts.scheme_as) begin
          // divider halts while the fifo is full so the flash is stalled
          if (fifo_ready) begin
            if (q.div == half_m1) begin
              d.div  = 4'h0;
              d.cclk = !q.cclk;
              if (q.cclk) begin
                if (q.cmdn < serial_config_pkg::CMD_BITS) begin
                  d.cmd  = {q.cmd[6:0], 1'b0};
                  d.cmdn = q.cmdn + 4'h1;
                end else begin
                  take = 1'b1;
                  w4   = opts.as_x4;
                  tb   = opts.as_x4 ? s_flash : {3'h0, s_flash[1]};
                end
              end
            end else begin
              d.div = q.div + 4'h1;
            end
          end
        end else if (ps_rise) begin
          take = 1'b1;
          tb   = {3'h0, s_data};
        end
        if (take) begin
          sh     = w4 ? {q.shreg[3:0], tb} : {q.shreg[6:0], tb[0]};
          nbn    = q.nb + (w4 ? 4'h4 : 4'h1);
          d.bits = q.bits + (w4 ? 24'h4 : 24'h1);
          if (nbn == serial_config_pkg::BYTE_BITS) begin
            d.push      = 1'b1;
            d.push_data = sh;
            nbn         = 4'h0;
          end
        end
        d.shreg = sh;
        d.nb    = nbn;
        if (d.err) begin
          d.st    = serial_config_pkg::ST_ERROR;
          d.sel_n = 1'b1;
        end else if (d.bits >= 24'(LOAD_BITS_P)) begin
          d.done  = 1'b1;
          d.sel_n = 1'b1;
          d.cclk  = 1'b0;
          d.cnt   = 16'h0;
          d.edges = 14'h0;
          if (opts.scheme_as) begin
            d.st = opts.init_user_clk ? serial_config_pkg::ST_INIT_USR : serial_config_pkg::ST_INIT_OSC;
          end else begin
            d.st = serial_config_pkg::ST_TRAIL;
          end
        end
      end
      serial_config_pkg::ST_TRAIL: begin
        d.init_low = opts.init_done_en;
        if (ps_fall) begin
          d.edges = q.edges + 14'h1;
          if (q.edges == 14'(serial_config_pkg::TRAIL_FALLS - 1)) begin
            d.edges = 14'h0;
            d.st    = opts.init_user_clk ? serial_config_pkg::ST_INIT_USR : serial_config_pkg::ST_INIT_OSC;
          end
        end
      end
      serial_config_pkg::ST_INIT_OSC: begin
        d.init_low = opts.init_done_en;
        d.cnt      = q.cnt + 16'h1;
        if (q.cnt == 16'(serial_config_pkg::UM_MIN_CYC - 1)) begin
          d.st = serial_config_pkg::ST_USER;
        end
      end
      serial_config_pkg::ST_INIT_USR: begin
        d.init_low = opts.init_done_en;
        if (q.cnt < 16'(serial_config_pkg::CD2CU_CYC)) begin
          d.cnt = q.cnt + 16'h1;
        end else if (u_rise) begin
          d.edges = q.edges + 14'h1;
          if (q.edges == 14'(USER_INIT_P - 1)) begin
            d.st = serial_config_pkg::ST_USER;
          end
        end
      end
      serial_config_pkg::ST_USER: begin
        d.user_mode    = 1'b1;
        d.init_low     = 1'b0;
        d.status_drive = 1'b0;
        d.done         = 1'b1;
        d.user_pin     = opts.dual_user;
      end
      serial_config_pkg::ST_ERROR: begin
        d.status_drive = 1'b1;
      end
      default: begin
        d.st = serial_config_pkg::ST_POR;
      end
    endcase
    if (req_fall && q.st != serial_config_pkg::ST_POR) begin
      d.st           = serial_config_pkg::ST_HOLD;
      d.cnt          = 16'h0;
      d.status_drive = 1'b1;
      d.done         = 1'b0;
      d.init_low     = 1'b0;
      d.user_mode    = 1'b0;
      d.user_pin     = 1'b0;
      d.sel_n        = 1'b1;
      d.cclk         = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      q              <= '0;
      q.st           <= serial_config_pkg::ST_POR;
      q.sel_n        <= 1'b1;
      q.status_drive <= 1'b1;
    end else begin
      q <= d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // buffer and pins
  cfg_byte_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in       (clk_in),
    .rst_in       (rst_in),
    .wr_data_in   (q.push_data),
    .wr_valid_in  (q.push),
    .wr_ready_out (fifo_ready),
    .rd_data_out  (byte_out),
    .rd_valid_out (byte_valid_out),
    .rd_ready_in  (byte_ready_in)
  );

  assign status_n_out         = 1'b0;
  assign status_n_oe_out      = q.status_drive;
  assign load_done_out        = q.done;
  assign init_done_n_out      = 1'b0;
  assign init_done_n_oe_out   = q.init_low;
  assign user_mode_out        = q.user_mode;
  assign config_clock_out     = q.cclk;
  assign config_clock_oe_out  = !q.sel_n;
  assign flash_command_out    = q.cmd[7];
  assign flash_select_n_out   = q.sel_n;
  assign user_pin_release_out = q.user_pin;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence s_req_fall;
    $fell(s_ncfg) && q.st != serial_config_pkg::ST_POR;
  endsequence

  sequence s_trail_first;
    q.st == serial_config_pkg::ST_TRAIL && ps_fall && q.edges == 14'h0;
  endsequence

  a_request_restart: assert property (s_req_fall |=> q.st == serial_config_pkg::ST_HOLD)
    else $error("request fall did not restart");
  a_user_levels: assert property (q.user_mode |-> !status_n_oe_out && load_done_out)
    else $error("user mode levels wrong");
  a_por_status: assert property (q.st == serial_config_pkg::ST_POR |-> status_n_oe_out)
    else $error("status not low in power-on delay");
  a_done_low: assert property (q.st inside {serial_config_pkg::ST_HOLD, serial_config_pkg::ST_RELEASE,
    serial_config_pkg::ST_LOAD, serial_config_pkg::ST_ERROR} |-> !load_done_out)
    else $error("done high during loading");
  a_done_complete: assert property ($rose(load_done_out) |-> q.bits >= 24'(LOAD_BITS_P) && !q.err)
    else $error("done rose early or after error");
  a_trail_two: assert property (s_trail_first |=> q.st == serial_config_pkg::ST_TRAIL)
    else $error("init began after one falling edge");
  a_init_pin: assert property ((opts.init_done_en && q.st inside {serial_config_pkg::ST_INIT_OSC,
    serial_config_pkg::ST_INIT_USR}) |=> init_done_n_oe_out || q.user_mode)
    else $error("init-done not driven low");
  a_chain_rate: assert property ((opts.chained && $rose(q.cclk)) |-> !$past(q.cclk, 2))
    else $error("chained load at top rate");
  a_status_min: assert property ((q.st == serial_config_pkg::ST_HOLD && d.st == serial_config_pkg::ST_RELEASE)
    |-> q.cnt >= 16'(serial_config_pkg::STATUS_MIN_CYC - 1))
    else $error("status pulse too short");
  a_request_fast: assert property (s_req_fall |-> ##[1:REQ_MAX] (status_n_oe_out && !load_done_out))
    else $error("request fall not answered in time");
  a_ps_bit: assert property ((q.st == serial_config_pkg::ST_LOAD && !opts.scheme_as && ps_rise && !req_fall)
    |=> q.bits == $past(q.bits) + 24'h1)
    else $error("passive edge did not take one bit");
  a_cmd_falling: assert property ((q.st == serial_config_pkg::ST_LOAD && $past(q.st) == serial_config_pkg::ST_LOAD
    && $changed(q.cmd)) |-> $fell(q.cclk))
    else $error("command moved off a falling edge");
  a_osc_bounds: assert property (q.st == serial_config_pkg::ST_INIT_OSC |-> q.cnt < 16'(UM_MAX_P))
    else $error("oscillator init too long");
  a_usr_init: assert property ((q.st == serial_config_pkg::ST_INIT_USR && d.st == serial_config_pkg::ST_USER)
    |-> q.cnt >= 16'(serial_config_pkg::CD2CU_CYC) && q.edges == 14'(USER_INIT_P - 1))
    else $error("user clock init cut short");
endmodule

`default_nettype wire

// file: testbench/passive_host_model.sv
// passive serial host model driving the configuration clock and data pin
`timescale 1ns/10ps
`default_nettype none

module passive_host_model (
  // host-driven pins
  output logic config_clock_out,
  output logic serial_data_out
);
  initial begin
    config_clock_out = 1'b0;
    serial_data_out  = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////

  // clock idles low between frames; released data shows the inverse level
  task automatic send_bytes(input int first, input int count);
    logic [7:0] b;
    for (int i = first; i < first + count; i++) begin
      b = 8'(i * 37 + 5);
      for (int k = 7; k >= 0; k--) begin
        serial_data_out = b[k];
        #400 config_clock_out = 1'b1;
        #400 config_clock_out = 1'b0;
      end
    end
    serial_data_out = ~serial_data_out;
  endtask

  task automatic trail_falls();
    repeat (2) begin
      #400 config_clock_out = 1'b1;
      #400 config_clock_out = 1'b0;
    end
  endtask
endmodule

`default_nettype wire

// file: testbench/serial_config_sequencer_tb_top.sv
// self-checking bench for the serial configuration sequencer
`timescale 1ns/10ps
`default_nettype none

module serial_config_sequencer_tb_top;
  logic                         clk_in, rst_in, req_n, ready, uclk, done_q;
  logic                         status_oe, done, init_oe, user_mode, release_o, byte_valid;
  logic                         cfg_clk, serial_data, status_n;
  logic                         cclk_o, cclk_oe, cclk_q, fcmd, fsel_n;
  logic [3:0]                   flash_d;
  logic [7:0]                   byte_o, cmd_seen;
  serial_config_pkg::cfg_opts_t opts;
  int                           error_cnt, check_count, cyc, done_cyc, rx_idx, cmd_n;

  // open-drain status wire with pull-up
  assign status_n = ~status_oe;

  serial_config_sequencer #(.LOAD_BITS_P(512), .USER_INIT_P(16)) serial_config_sequencer_i (
    .clk_in(clk_in), .rst_in(rst_in), .opts_in(opts), .config_request_n_in(req_n),
    .status_n_in(status_n), .status_n_out(), .status_n_oe_out(status_oe), .load_done_out(done),
    .init_done_n_out(), .init_done_n_oe_out(init_oe), .user_mode_out(user_mode),
    .config_clock_in(cfg_clk), .config_clock_out(cclk_o), .config_clock_oe_out(cclk_oe),
    .serial_data_in(serial_data), .user_pin_release_out(release_o),
    .serial_flash_data_in(flash_d), .flash_command_out(fcmd), .flash_select_n_out(fsel_n),
    .user_startup_clock_in(uclk), .byte_out(byte_o), .byte_valid_out(byte_valid),
    .byte_ready_in(ready));

  passive_host_model passive_host_model_i (.config_clock_out(cfg_clk), .serial_data_out(serial_data));

  ////////////////////////////////////////////////////////////////////////////////

  task automatic check(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  task automatic wrap_up();
    if (error_cnt == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge clk_in) begin
    cyc    <= cyc + 1;
    done_q <= done;
    cclk_q <= cclk_o;
    if (done === 1'b1 && done_q !== 1'b1) done_cyc <= cyc;
    if (byte_valid === 1'b1 && ready === 1'b1) begin
      check(byte_o === (opts.scheme_as ? 8'haa : 8'(rx_idx * 37 + 5)), "received byte differs");
      rx_idx <= rx_idx + 1;
    end
    // command bit stands while the flash clock is high
    if (fsel_n === 1'b0 && cclk_oe === 1'b1 && cclk_o === 1'b1 && cclk_q !== 1'b1 && cmd_n < 8) begin
      cmd_seen <= {cmd_seen[6:0], fcmd};
      cmd_n    <= cmd_n + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  task automatic do_reset();
    rst_in = 1'b1;
    repeat (4) @(negedge clk_in);
    rst_in = 1'b0;
  endtask

  task automatic por_check();
    check(status_oe === 1'b1 && done === 1'b0 && user_mode === 1'b0, "power-up outputs");
    repeat (66) @(negedge clk_in);
    check(status_oe === 1'b1 && done === 1'b0, "status released early");
  endtask

  task automatic request_cycle();
    int n;
    int t0;
    req_n = 1'b0;
    t0 = cyc;
    for (n = 0; n < 6 && !(status_oe === 1'b1 && done === 1'b0); n++) @(negedge clk_in);
    check(n < 6 && user_mode === 1'b0, "request not answered in time");
    repeat (20) @(negedge clk_in);
    req_n = 1'b1;
    for (n = 0; n < 16000 && status_oe !== 1'b0; n++) @(negedge clk_in);
    check(cyc - t0 >= 2680 && cyc - t0 <= 15060, "status pulse width");
    check(done === 1'b0, "done high before load");
    if (n == 16000) wrap_up();
    repeat (21) @(negedge clk_in);
  endtask

  task automatic load_and_init(input logic user_clk);
    int n;
    rx_idx = 0;
    passive_host_model_i.send_bytes(0, 63);
    check(done === 1'b0, "done before last byte");
    passive_host_model_i.send_bytes(63, 1);
    repeat (10) @(negedge clk_in);
    check(done === 1'b1 && rx_idx == 64, "load incomplete");
    passive_host_model_i.trail_falls();
    check(init_oe === 1'b1, "init-done not driven low");
    if (user_clk) begin
      repeat (20) @(negedge clk_in);
      repeat (15) begin
        #400 uclk = 1'b1;
        #400 uclk = 1'b0;
      end
      check(user_mode === 1'b0, "user mode before start-up cycles");
      #400 uclk = 1'b1;
      #400 uclk = 1'b0;
    end
    for (n = 0; n < 5000 && user_mode !== 1'b1; n++) @(negedge clk_in);
    if (!user_clk) check(cyc - done_cyc >= 1750 && cyc - done_cyc <= 4370, "init duration");
    check(user_mode === 1'b1 && status_oe === 1'b0 && done === 1'b1, "user mode levels");
    check(init_oe === 1'b0 && release_o === opts.dual_user, "pins after init");
    if (n == 5000) wrap_up();
  endtask

  task automatic active_load();
    int n;
    for (n = 0; n < 3000 && user_mode !== 1'b1; n++) @(negedge clk_in);
    check(cmd_seen === serial_config_pkg::FLASH_READ_CMD && cmd_n == 8, "flash read command");
    check(rx_idx == 64 && done === 1'b1 && user_mode === 1'b1, "active load incomplete");
    check(cyc - done_cyc >= 1750 && cyc - done_cyc <= 4370, "active init duration");
    check(status_oe === 1'b0 && init_oe === 1'b0 && fsel_n === 1'b1 && cclk_oe === 1'b0, "active pins");
  endtask

  task automatic overflow_check();
    int n;
    ready = 1'b0;
    rx_idx = 0;
    passive_host_model_i.send_bytes(0, 33);
    repeat (10) @(negedge clk_in);
    check(status_oe === 1'b1 && done === 1'b0, "overflow not refused");
    ready = 1'b1;
    for (n = 0; n < 100 && byte_valid === 1'b1; n++) @(negedge clk_in);
    check(byte_valid === 1'b0, "fifo not drained");
  endtask

  ////////////////////////////////////////////////////////////////////////////////

  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  initial begin
    rst_in = 1'b1;
    req_n = 1'b1;
    ready = 1'b1;
    uclk = 1'b0;
    done_q = 1'b0;
    error_cnt = 0;
    check_count = 0;
    cyc = 0;
    done_cyc = 0;
    rx_idx = 0;
    cclk_q = 1'b0;
    flash_d = 4'h0;
    cmd_seen = 8'h00;
    cmd_n = 0;
    opts = 8'h03;
    do_reset();
    por_check();
    request_cycle();
    load_and_init(1'b0);
    request_cycle();
    overflow_check();
    request_cycle();
    opts = 8'h06;
    do_reset();
    repeat (70) @(negedge clk_in);
    request_cycle();
    load_and_init(1'b1);
    // active x4, chained at the top rate setting, flash streams a fixed nibble
    opts = 8'hfa;
    flash_d = 4'ha;
    rx_idx = 0;
    cmd_n = 0;
    request_cycle();
    active_load();
    wrap_up();
  end
endmodule

`default_nettype wire
